//--- common/aos_map.vh
// Register map, field positions and timing constants of the angle output shaping block
`ifndef AOS_MAP_VH
`define AOS_MAP_VH
// Register byte offsets
`define AOS_ANGLE_REFERENCE      8'h00
`define AOS_ANGLE_PRE_SHIFT      8'h04
`define AOS_OUTPUT_GAIN_FACTOR   8'h08
`define AOS_OUTPUT_SHIFT_VALUE   8'h0c
`define AOS_LOWER_LIMIT_LEVEL    8'h10
`define AOS_UPPER_LIMIT_LEVEL    8'h14
`define AOS_FIELD_LOW_THRESHOLD  8'h18
`define AOS_FIELD_HIGH_THRESHOLD 8'h1c
`define AOS_LOWPASS_CUTOFF_SEL   8'h20
`define AOS_SENSOR_CONFIG_WORD   8'h24
`define AOS_MODULO_SELECT        8'h28
`define AOS_STATUS               8'h2c
`define AOS_OUTPUT_VALUE         8'h30
`define AOS_SETPOINT_BASE        8'h40
// Number of linearization setpoints
`define AOS_NUM_SETPOINTS        33
`define AOS_SETPOINT_SPACING     1024
// Setup word fields
`define AOS_CFG_SELFTEST_CONT    14
`define AOS_CFG_COMM_FAST        13
`define AOS_CFG_DIGITAL_FORMAT   12
`define AOS_CFG_PULSE_RATE_HI    11
`define AOS_CFG_PULSE_RATE_LO    10
`define AOS_CFG_SHORT_HI         9
`define AOS_CFG_SHORT_LO         8
`define AOS_CFG_ERROR_BAND       7
`define AOS_CFG_BURN_IN          6
`define AOS_CFG_FUNC_NORMAL      5
`define AOS_CFG_PIN_COMM         4
`define AOS_CFG_OVERVOLT         3
`define AOS_CFG_DIAG_LATCH       2
`define AOS_CFG_DIAG_NOFORCE     1
`define AOS_CFG_LOCK             0
// Reset values
`define AOS_GAIN_RESET           16'h0400
`define AOS_UPPER_RESET          16'h7fff
`define AOS_FIELD_HIGH_RESET     16'h7fff
`define AOS_CONFIG_RESET         16'h0000
// Filter bypass code
`define AOS_LP_BYPASS            16'h0000
// Bit times of the pin protocol, in ns, and cycle counts at 40 MHz
`define AOS_CLK_PERIOD_NS        25
`define AOS_BIT_SLOW_NS          1000000
`define AOS_BIT_FAST_NS          250000
`define AOS_BIT_SLOW_CYC         (`AOS_BIT_SLOW_NS / `AOS_CLK_PERIOD_NS)
`define AOS_BIT_FAST_CYC         (`AOS_BIT_FAST_NS / `AOS_CLK_PERIOD_NS)
`endif

//--- logic/aos_angle_output_shaping.v
// Angle output shaping stage with AXI4-Lite register access
//
// What this block does
// - Angle reference register shifts the setpoint origin
// - Pre-shift register avoids path overflow
// - Signed gain, 1.0 maps full turn to full scale
// - Signed offset spanning minus to plus 200 percent
// - Output clamped between lower and upper levels
// - Field out of range forces high clamp
// - Two separate signed field thresholds
// - First-order low-pass, code selects cutoff
// - Modulo folding into 90 or 120 degree segments
// - 33-setpoint, 32-segment linear interpolation correction
// - Bit 14 selects continuous memory self-test
// - Bit 13 selects pin protocol bit time
// - Bit 12 selects PWM or SENT format
// - Bits 11:10 select the PWM frequency
// - Bits 9:8 control output short detection
// - Bit 7 error band, high when unlocked
// - Burn-in, functionality and pin communication bits
// - Bit 2 latches diagnosis until reset
// - Bit 1 decides error-band forcing on diagnosis; short hits in modes 1 and 2 force it regardless
// - Bit 0 locks customer memory
`include "aos_map.vh"
`default_nettype none
module aos_angle_output_shaping #(
  parameter integer BIT_SLOW_CYC = `AOS_BIT_SLOW_CYC,
  parameter integer BIT_FAST_CYC = `AOS_BIT_FAST_CYC
) (
  // Clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Sample input from the angle and magnitude path
  input  wire [15:0] angleIn,
  input  wire [15:0] fieldMagnitude,
  input  wire        sampleValid,
  // Diagnosis events from elsewhere in the sensor
  input  wire        diagEvent,
  input  wire        shortHighDetect,
  input  wire        shortLowDetect,
  // Shaped output and steering
  output reg  [15:0] outputValue,
  output reg         outputValid,
  output reg         fieldRangeError,
  output reg         diagFlag,
  output wire        errorBandLow,
  output wire        forceErrorBand,
  output wire        outputTristate,
  output wire        driveInvert,
  output wire        selfTestContinuous,
  output wire        digitalFormatSelect,
  output wire [1:0]  pulseRateSelect,
  output wire        burnInEnable,
  output wire        functionNormal,
  output wire        pinCommEnable,
  output wire        overvoltageDetect,
  output wire        memoryLocked,
  output wire [31:0] commBitCycles
);

  localparam NSP = `AOS_NUM_SETPOINTS;

  // Software-visible registers
  reg [15:0] angleReference;
  reg [15:0] anglePreShift;
  reg [15:0] outputGainFactor;
  reg [15:0] outputShiftValue;
  reg [15:0] lowerLimitLevel;
  reg [15:0] upperLimitLevel;
  reg [15:0] fieldLowThreshold;
  reg [15:0] fieldHighThreshold;
  reg [15:0] lowpassCutoffSelect;
  reg [15:0] sensorConfigWord;
  reg [1:0]  moduloSelect;
  reg [15:0] setpoint [0:NSP-1];

  // Write channel bookkeeping
  reg        awHeld;
  reg        wHeld;
  reg [7:0]  awAddr;
  reg [31:0] wData;
  reg [3:0]  wStrb;
  wire       doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire       locked  = sensorConfigWord[`AOS_CFG_LOCK];

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  stb;
    begin
      merge16 = {stb[1] ? dat[15:8] : old[15:8], stb[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  wire isSetpoint = (awAddr >= `AOS_SETPOINT_BASE) && (awAddr < (`AOS_SETPOINT_BASE + 4 * NSP));
  wire [5:0] wIdx = awAddr[7:2] - 6'h10;
  wire writeMapped = (awAddr <= `AOS_MODULO_SELECT) || isSetpoint;

  // Address and data capture, then one write, then the response
  always @(posedge clock) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Locked memory refuses writes, slave error reported
        s_axi_bresp <= (!writeMapped || awAddr[1:0] != 2'h0) ? 2'h3 : (locked ? 2'h2 : 2'h0);
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wrOk = doWrite && !locked && awAddr[1:0] == 2'h0;

  // Configuration registers; reference and pre-shift start at zero
  always @(posedge clock) begin
    if (sys_rst) begin
      angleReference <= 16'h0000;
      anglePreShift <= 16'h0000;
      outputGainFactor <= `AOS_GAIN_RESET;
      outputShiftValue <= 16'h0000;
      lowerLimitLevel <= 16'h0000;
      upperLimitLevel <= `AOS_UPPER_RESET;
      fieldLowThreshold <= 16'h0000;
      fieldHighThreshold <= `AOS_FIELD_HIGH_RESET;
      lowpassCutoffSelect <= `AOS_LP_BYPASS;
      sensorConfigWord <= `AOS_CONFIG_RESET;
      moduloSelect <= 2'h0;
    end else if (wrOk) begin
      case (awAddr)
        `AOS_ANGLE_REFERENCE:      angleReference <= merge16(angleReference, wData, wStrb);
        `AOS_ANGLE_PRE_SHIFT:      anglePreShift <= merge16(anglePreShift, wData, wStrb);
        `AOS_OUTPUT_GAIN_FACTOR:   outputGainFactor <= merge16(outputGainFactor, wData, wStrb);
        `AOS_OUTPUT_SHIFT_VALUE:   outputShiftValue <= merge16(outputShiftValue, wData, wStrb);
        `AOS_LOWER_LIMIT_LEVEL:    lowerLimitLevel <= merge16(lowerLimitLevel, wData, wStrb);
        `AOS_UPPER_LIMIT_LEVEL:    upperLimitLevel <= merge16(upperLimitLevel, wData, wStrb);
        `AOS_FIELD_LOW_THRESHOLD:  fieldLowThreshold <= merge16(fieldLowThreshold, wData, wStrb);
        `AOS_FIELD_HIGH_THRESHOLD: fieldHighThreshold <= merge16(fieldHighThreshold, wData, wStrb);
        `AOS_LOWPASS_CUTOFF_SEL:   lowpassCutoffSelect <= merge16(lowpassCutoffSelect, wData, wStrb);
        `AOS_SENSOR_CONFIG_WORD:   sensorConfigWord <= merge16(sensorConfigWord, wData, wStrb) & 16'h7fff;
        `AOS_MODULO_SELECT:        moduloSelect <= wStrb[0] ? wData[1:0] : moduloSelect;
        default: ;
      endcase
    end
  end

  // Setpoint table, one flip-flop word per entry
  genvar g;
  generate
    for (g = 0; g < NSP; g = g + 1) begin : gSetpoint
      always @(posedge clock) begin
        if (sys_rst) begin
          setpoint[g] <= 16'h0000;
        end else if (wrOk && isSetpoint && wIdx == g) begin
          setpoint[g] <= merge16(setpoint[g], wData, wStrb);
        end
      end
    end
  endgenerate

  // Status word read back by software
  wire [15:0] statusWord = {12'h000, locked, diagFlag, fieldRangeError, outputValid};

  // Read decode, one cycle to answer
  reg [31:0] rdMux;
  reg        rdOk;
  wire [5:0] rIdx = s_axi_araddr[7:2] - 6'h10;
  always @* begin
    rdOk = (s_axi_araddr[1:0] == 2'h0);
    rdMux = 32'h00000000;
    case (s_axi_araddr)
      `AOS_ANGLE_REFERENCE:      rdMux = {16'h0000, angleReference};
      `AOS_ANGLE_PRE_SHIFT:      rdMux = {16'h0000, anglePreShift};
      `AOS_OUTPUT_GAIN_FACTOR:   rdMux = {16'h0000, outputGainFactor};
      `AOS_OUTPUT_SHIFT_VALUE:   rdMux = {16'h0000, outputShiftValue};
      `AOS_LOWER_LIMIT_LEVEL:    rdMux = {16'h0000, lowerLimitLevel};
      `AOS_UPPER_LIMIT_LEVEL:    rdMux = {16'h0000, upperLimitLevel};
      `AOS_FIELD_LOW_THRESHOLD:  rdMux = {16'h0000, fieldLowThreshold};
      `AOS_FIELD_HIGH_THRESHOLD: rdMux = {16'h0000, fieldHighThreshold};
      `AOS_LOWPASS_CUTOFF_SEL:   rdMux = {16'h0000, lowpassCutoffSelect};
      `AOS_SENSOR_CONFIG_WORD:   rdMux = {16'h0000, sensorConfigWord};
      `AOS_MODULO_SELECT:        rdMux = {30'h00000000, moduloSelect};
      `AOS_STATUS:               rdMux = {16'h0000, statusWord};
      `AOS_OUTPUT_VALUE:         rdMux = {16'h0000, outputValue};
      default: begin
        if (s_axi_araddr >= `AOS_SETPOINT_BASE && rIdx < NSP) begin
          rdMux = {16'h0000, setpoint[rIdx]};
        end else begin
          rdOk = 1'b0;
        end
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdOk ? rdMux : 32'h00000000;
      s_axi_rresp <= rdOk ? 2'h0 : 2'h3;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Stage 1: pre-shift, reference, modulo folding
  wire [15:0] shifted = angleIn + anglePreShift - angleReference;
  reg  [15:0] folded;
  reg  [15:0] foldBase;
  reg  [17:0] foldProd;
  always @* begin
    // Start of the 120 degree segment the angle sits in
    foldBase = 16'h0000;
    if (shifted >= 16'haaaa) begin
      foldBase = 16'haaaa;
    end else if (shifted >= 16'h5555) begin
      foldBase = 16'h5555;
    end
    // Stretch one segment back to a full turn; top bits are the wrap
    foldProd = (shifted - foldBase) * 2'd3;
    case (moduloSelect)
      2'h1: folded = {shifted[13:0], 2'h0}; // 90 degree segments rescaled
      2'h2: folded = foldProd[15:0];
      default: folded = shifted;
    endcase
  end

  // Gain in 6.10 fixed point (1024 = 1.0), offset in units of 1/16384 of full scale
  wire signed [32:0] scaled   = $signed({1'b0, folded}) * $signed(outputGainFactor);
  wire signed [32:0] offAdd   = $signed(outputShiftValue) <<< 1; // 32768 gives -200 percent
  wire signed [32:0] gained   = (scaled >>> 11) + offAdd;
  wire        [15:0] linIn    = gained < 0 ? 16'h0000 : gained > 33'sd32768 ? 16'h8000 : gained[15:0];

  // Segment pick and interpolation across 1024-wide steps
  wire [5:0]  seg    = linIn[15] ? 6'd31 : {1'b0, linIn[14:10]};
  wire [10:0] frac   = linIn[15] ? 11'd1024 : {1'b0, linIn[9:0]};
  wire signed [16:0] spA = $signed(setpoint[seg]);
  wire signed [16:0] spB = $signed(setpoint[seg + 6'd1]);
  wire signed [28:0] delta = (spB - spA) * $signed({1'b0, frac});
  wire signed [28:0] deltaStep = delta >>> 10;
  // Step never exceeds a 17-bit span, upper bits are sign only
  wire signed [16:0] linOut = spA + deltaStep[16:0];

  // First-order low-pass; shift amount from the cutoff code, zero bypasses
  wire [3:0] lpShift = lowpassCutoffSelect[3:0];
  reg  signed [31:0] filtAcc;
  wire signed [31:0] linWide = {{15{linOut[16]}}, linOut};
  wire signed [31:0] filtOut = filtAcc >>> lpShift;

  // Field range check against the two thresholds
  wire fieldBad = $signed(fieldMagnitude) < $signed(fieldLowThreshold) ||
                  $signed(fieldMagnitude) > $signed(fieldHighThreshold);

  // Clamp; field error overrides with the high clamp
  wire signed [31:0] lo = $signed({{16{lowerLimitLevel[15]}}, lowerLimitLevel});
  wire signed [31:0] hi = $signed({{16{upperLimitLevel[15]}}, upperLimitLevel});
  wire signed [31:0] pre = (lpShift == 4'h0) ? linWide : filtOut;
  wire [15:0] clamped = fieldBad ? upperLimitLevel : pre < lo ? lowerLimitLevel
                      : pre > hi ? upperLimitLevel : pre[15:0];

  // Output pipeline register and filter state
  always @(posedge clock) begin
    if (sys_rst) begin
      filtAcc <= 32'sd0;
      outputValue <= 16'h0000;
      outputValid <= 1'b0;
      fieldRangeError <= 1'b0;
    end else begin
      outputValid <= sampleValid;
      if (sampleValid) begin
        // Accumulator holds output scaled by 2^shift, so no precision is lost
        filtAcc <= filtAcc + linWide - filtOut;
        outputValue <= clamped;
        fieldRangeError <= fieldBad;
      end
    end
  end

  // Diagnosis flag, latched until reset when asked to; set beats release
  always @(posedge clock) begin
    if (sys_rst) begin
      diagFlag <= 1'b0;
    end else if (diagEvent || (sampleValid && fieldBad)) begin
      diagFlag <= 1'b1;
    end else if (!sensorConfigWord[`AOS_CFG_DIAG_LATCH]) begin
      diagFlag <= 1'b0;
    end
  end

  // Short detection steering by mode
  wire [1:0] shortMode = sensorConfigWord[`AOS_CFG_SHORT_HI:`AOS_CFG_SHORT_LO];
  wire shortHit = (shortMode == 2'h3) ? shortLowDetect
                : (shortMode != 2'h0) && (shortHighDetect || shortLowDetect);
  assign outputTristate = (shortMode == 2'h3) && shortLowDetect;
  assign driveInvert    = (shortMode == 2'h2);

  // Unlocked parts always use the high band
  assign errorBandLow   = locked && sensorConfigWord[`AOS_CFG_ERROR_BAND];
  assign forceErrorBand = (diagFlag && !sensorConfigWord[`AOS_CFG_DIAG_NOFORCE]) ||
                          ((shortMode == 2'h1 || shortMode == 2'h2) && shortHit);

  // Setup word decode to the rest of the sensor
  assign selfTestContinuous  = sensorConfigWord[`AOS_CFG_SELFTEST_CONT];
  assign commBitCycles       = sensorConfigWord[`AOS_CFG_COMM_FAST] ? BIT_FAST_CYC : BIT_SLOW_CYC;
  assign digitalFormatSelect = sensorConfigWord[`AOS_CFG_DIGITAL_FORMAT];
  assign pulseRateSelect     = sensorConfigWord[`AOS_CFG_PULSE_RATE_HI:`AOS_CFG_PULSE_RATE_LO];
  assign burnInEnable        = sensorConfigWord[`AOS_CFG_BURN_IN];
  assign functionNormal      = sensorConfigWord[`AOS_CFG_FUNC_NORMAL];
  assign pinCommEnable       = sensorConfigWord[`AOS_CFG_PIN_COMM];
  assign overvoltageDetect   = !sensorConfigWord[`AOS_CFG_OVERVOLT];
  assign memoryLocked        = locked;

endmodule // aos_angle_output_shaping
`default_nettype wire

//--- tb/aos_output_checker_assertions.sv
// Port-level assertions for the angle output shaping block
`default_nettype none
module aos_output_checker #(
  parameter integer BIT_SLOW_CYC = 40,
  parameter integer BIT_FAST_CYC = 10
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // Register bus handshakes
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Sample path
  input wire logic        sampleValid,
  input wire logic        outputValid,
  input wire logic [15:0] outputValue,
  input wire logic        fieldRangeError,
  // Setup decode
  input wire logic        errorBandLow,
  input wire logic        memoryLocked,
  input wire logic [31:0] commBitCycles
);
  // One clock domain, reset kills every attempt
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_sample_answer: assert property (sampleValid |=> outputValid)
    else $error("no output one cycle after a sample");
  a_no_spurious: assert property (!sampleValid |=> !outputValid)
    else $error("output valid without a sample");
  a_output_holds: assert property (!sampleValid |=> $stable(outputValue))
    else $error("output value moved between samples");
  a_range_holds: assert property (!sampleValid |=> $stable(fieldRangeError))
    else $error("field range flag moved between samples");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped before rready");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while a read is pending");
  a_band_unlocked: assert property (!memoryLocked |-> !errorBandLow)
    else $error("low error band while unlocked");
  a_bit_time: assert property (commBitCycles == BIT_FAST_CYC || commBitCycles == BIT_SLOW_CYC)
    else $error("bit time is neither fast nor slow");

  // Main scenarios seen
  c_field_error: cover property (sampleValid ##1 (outputValid && fieldRangeError));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_locked_low: cover property (memoryLocked && errorBandLow);
endmodule // aos_output_checker

bind aos_angle_output_shaping aos_output_checker #(.BIT_SLOW_CYC(BIT_SLOW_CYC), .BIT_FAST_CYC(BIT_FAST_CYC))
  aos_output_checker_inst (.clock(clock), .sys_rst(sys_rst), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sampleValid(sampleValid),
  .outputValid(outputValid), .outputValue(outputValue), .fieldRangeError(fieldRangeError),
  .errorBandLow(errorBandLow), .memoryLocked(memoryLocked), .commBitCycles(commBitCycles));
`default_nettype wire

//--- tb/aos_output_reader.sv
// Model of the controller that reads the shaped output
`default_nettype none
module aos_output_reader (
  // Clock
  input  wire logic        clock,
  // Output stage
  input  wire logic        outputValid,
  input  wire logic [15:0] outputValue,
  // Last value received
  output var  logic [15:0] rxValue
);
  // Capture on the valid pulse only, a late read would miss a back-to-back sample
  always_ff @(posedge clock) begin
    if (outputValid) begin
      rxValue <= outputValue;
    end
  end
endmodule // aos_output_reader
`default_nettype wire

//--- tb/aos_angle_output_shaping_tb.sv
// Self-checking bench for the angle output shaping block
`default_nettype none
module aos_angle_output_shaping_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer SLOW = 40;
  localparam integer FAST = 10;
  // Bench-driven inputs
  logic        clock = 1'h0, sys_rst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, sampleValid = 1'h0, diagEvent = 1'h0, shortHighDetect = 1'h0, shortLowDetect = 1'h0;
  logic [15:0] angleIn = 16'h0, fieldMagnitude = 16'h0;
  // Design outputs
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, outputValid, fieldRangeError;
  wire         diagFlag, errorBandLow, forceErrorBand, outputTristate, driveInvert, selfTestContinuous;
  wire         digitalFormatSelect, burnInEnable, functionNormal, pinCommEnable, overvoltageDetect, memoryLocked;
  wire [1:0]   s_axi_bresp, s_axi_rresp, pulseRateSelect;
  wire [31:0]  s_axi_rdata, commBitCycles;
  wire [15:0]  outputValue, rxValue;
  // Bench state
  int          n_errors = 0, comparisons = 0, i;
  logic [1:0]  resp;
  logic [31:0] rd, v;
  logic [15:0] a;
  logic [7:0]  rstAddr [5] = '{8'h00, 8'h08, 8'h14, 8'h1c, 8'h24};
  logic [31:0] rstVal [5] = '{32'h0, 32'h400, 32'h7fff, 32'h7fff, 32'h0};
  logic [31:0] pathVal [9] = '{32'h0, 32'h0, 32'h400, 32'h0, 32'h0, 32'h7fff, 32'h0, 32'h7fff, 32'h0};

  // Clock at 40 MHz
  always #12.5 clock = ~clock;

  aos_angle_output_shaping #(.BIT_SLOW_CYC(SLOW), .BIT_FAST_CYC(FAST)) aos_angle_output_shaping_inst (
    .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .angleIn(angleIn), .fieldMagnitude(fieldMagnitude), .sampleValid(sampleValid), .diagEvent(diagEvent),
    .shortHighDetect(shortHighDetect), .shortLowDetect(shortLowDetect), .outputValue(outputValue),
    .outputValid(outputValid), .fieldRangeError(fieldRangeError), .diagFlag(diagFlag),
    .errorBandLow(errorBandLow), .forceErrorBand(forceErrorBand), .outputTristate(outputTristate),
    .driveInvert(driveInvert), .selfTestContinuous(selfTestContinuous), .digitalFormatSelect(digitalFormatSelect),
    .pulseRateSelect(pulseRateSelect), .burnInEnable(burnInEnable), .functionNormal(functionNormal),
    .pinCommEnable(pinCommEnable), .overvoltageDetect(overvoltageDetect), .memoryLocked(memoryLocked),
    .commBitCycles(commBitCycles));

  aos_output_reader aos_output_reader_inst (.clock(clock), .outputValid(outputValid), .outputValue(outputValue),
    .rxValue(rxValue));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write with both channels offered together, bready held until the answer
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    int t;
    @(posedge clock);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (t = 0; t < 50; t++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
    if (t == 50) n_errors++;
    #1;
  endtask

  // Read, data taken at the rvalid edge
  task automatic axr(input logic [7:0] ad);
    int t;
    @(posedge clock);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (t = 0; t < 50; t++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
    if (t == 50) n_errors++;
  endtask

  // One sample pulse, result seen through the reader
  task automatic samp(input logic [15:0] ang, input logic [15:0] m, input logic [31:0] e, input logic fe);
    @(posedge clock);
    angleIn <= ang;
    fieldMagnitude <= m;
    sampleValid <= 1'h1;
    @(posedge clock);
    sampleValid <= 1'h0;
    @(posedge clock);
    #1;
    chk(32'(rxValue), e);
    chk(32'(fieldRangeError), 32'(fe));
  endtask

  // Gain one maps a turn to half the code range, offset counts double
  function automatic logic [31:0] expOut(input logic [15:0] ang, input logic [15:0] off, input int lo, input int hi);
    int r;
    r = int'(ang >> 1) + 2 * int'($signed(off));
    r = (r > hi) ? hi : ((r < lo) ? lo : r);
    return 32'(r);
  endfunction

  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h3efb));
    repeat (10) @(posedge clock);
    sys_rst <= 1'h0;
    for (i = 0; i < 5; i++) begin
      axr(rstAddr[i]);
      chk(rd, rstVal[i]);
    end
    for (i = 0; i < 9; i++) begin
      v = $urandom;
      axw(8'(4 * i), v);
      axr(8'(4 * i));
      chk(rd, {16'h0, v[15:0]});
    end
    axr(8'h3c);
    chk({rd[31:1], rd[0] | (resp === 2'h0)}, 32'h0);
    // Identity setpoints, monotonic and 1024 apart
    for (i = 0; i < 33; i++) axw(8'(8'h40 + 4 * i), 32'(i * 1024));
    for (i = 0; i < 9; i++) axw(8'(4 * i), pathVal[i]);
    samp(16'h0000, 16'h0100, 32'h0, 1'h0);
    samp(16'h0800, 16'h0100, 32'h400, 1'h0);
    repeat (20) begin
      a = 16'($urandom_range(32'hf7ff));
      samp(a, 16'($urandom_range(32'h7ffe, 32'h1)), expOut(a, 16'h0, 0, 32767), 1'h0);
    end
    axw(8'h0c, 32'h0100);
    samp(16'h2000, 16'h0100, expOut(16'h2000, 16'h0100, 0, 32767), 1'h0);
    axw(8'h0c, 32'hff00);
    samp(16'h2000, 16'h0100, expOut(16'h2000, 16'hff00, 0, 32767), 1'h0);
    axw(8'h0c, 32'h0);
    axw(8'h10, 32'h1000);
    axw(8'h14, 32'h4000);
    samp(16'h1000, 16'h0100, expOut(16'h1000, 16'h0, 4096, 16384), 1'h0);
    samp(16'hc000, 16'h0100, expOut(16'hc000, 16'h0, 4096, 16384), 1'h0);
    axw(8'h18, 32'h0100);
    axw(8'h1c, 32'h1000);
    samp(16'h2000, 16'h2000, 32'h4000, 1'h1);
    samp(16'h2000, 16'h0010, 32'h4000, 1'h1);
    samp(16'h2000, 16'h0800, 32'h1000, 1'h0);
    axw(8'h28, 32'h1);
    samp(16'h1000, 16'h0800, 32'h2000, 1'h0);
    axw(8'h28, 32'h2);
    samp(16'h6000, 16'h0800, 32'h1000, 1'h0);
    // Every pulse rate and short code, setup bits 14 down to 4 toggled alongside
    for (i = 0; i < 4; i++) begin
      v = 32'((i << 10) | (i << 8) | ((i & 1) << 13) | ((i >> 1) << 12) | ((i & 1) << 14) | ((i >> 1) << 6));
      axw(8'h24, v | 32'((i & 1) << 5) | 32'((i >> 1) << 4) | 32'((i & 1) << 7));
      chk({outputTristate, driveInvert, overvoltageDetect}, {1'h0, i == 2, 1'h1});
      chk(32'(pulseRateSelect), 32'(i));
      chk(commBitCycles, (i & 1) ? 32'(FAST) : 32'(SLOW));
      chk({selfTestContinuous, digitalFormatSelect, burnInEnable, functionNormal, pinCommEnable, errorBandLow},
          {v[14], v[12], v[6], v[13], v[12], 1'h0});
    end
    axw(8'h24, 32'h0004);
    @(posedge clock);
    diagEvent <= 1'h1;
    @(posedge clock);
    diagEvent <= 1'h0;
    repeat (3) @(posedge clock);
    #1;
    chk(32'(diagFlag), 32'h1);
    chk(32'(forceErrorBand), 32'h1);
    axw(8'h24, 32'h0006);
    chk(32'(forceErrorBand), 32'h0);
    axw(8'h24, 32'h0081);
    chk({memoryLocked, errorBandLow}, 2'h3);
    axw(8'h08, 32'h1234);
    chk(32'(resp), 32'h2);
    axr(8'h08);
    chk(rd, 32'h400);
    finish_test();
  end
endmodule // aos_angle_output_shaping_tb
`default_nettype wire
